// ---- include/rwc_cfg.svh ----
`ifndef RWC_CFG_SVH
`define RWC_CFG_SVH

// clock and watchdog oscillator rates
`define RWC_CLK_HZ 100000000
`define RWC_WDT_OSC_HZ 128000
`define RWC_WDT_DIV_CYC (`RWC_CLK_HZ / `RWC_WDT_OSC_HZ)

// reset stretch period after the last source releases
`define RWC_STRETCH_US 64
`define RWC_STRETCH_CYC (`RWC_STRETCH_US * (`RWC_CLK_HZ / 1000000))

// least persistence of a pin reset and of a brown-out indication
`define RWC_EXT_MIN_NS 2500
`define RWC_EXT_MIN_CYC ((`RWC_EXT_MIN_NS * (`RWC_CLK_HZ / 1000000) + 999) / 1000)
`define RWC_BOD_MIN_NS 2000
`define RWC_BOD_MIN_CYC ((`RWC_BOD_MIN_NS * (`RWC_CLK_HZ / 1000000) + 999) / 1000)

// length of the watchdog reset pulse
`define RWC_WDT_PULSE_NS 40
`define RWC_WDT_PULSE_CYC ((`RWC_WDT_PULSE_NS * (`RWC_CLK_HZ / 1000000) + 999) / 1000)

// register indices, byte address is four times the index
`define RWC_IDX_WDT_CTRL 8'h31
`define RWC_IDX_CAUSE 8'h3b
`define RWC_IDX_CMP_CTRL 8'h3e
`define RWC_IDX_UNLOCK 8'h3f

// watchdog_control_register fields
`define RWC_WDC_IRQ_FLAG 7
`define RWC_WDC_IRQ_EN 6
`define RWC_WDC_SEL3 5
`define RWC_WDC_RESET_EN 3
`define RWC_WDC_SEL_HI 2

// reset_cause_register fields
`define RWC_CAUSE_WDT 3
`define RWC_CAUSE_BOD 2
`define RWC_CAUSE_EXT 1
`define RWC_CAUSE_POR 0

// comparator_control_register field
`define RWC_CMP_BANDGAP 0

// protected change sequence
`define RWC_UNLOCK_SIG 8'hd8
`define RWC_UNLOCK_WIN 3'h4

// watchdog period table
`define RWC_WDT_BASE_CYC 21'h000800
`define RWC_WDT_SEL_MAX 4'h9

// reset values
`define RWC_RESET_VECTOR 16'h0000
`define RWC_BOD_FUSE_OFF 3'h7

`endif

// ---- include/rwc_pkg.sv ----
package rwc_pkg;

  typedef enum logic [1:0] {
    rwc_hold,
    rwc_stretch,
    rwc_run
  } rwc_state_e;

  typedef logic [19:0] rwc_wdt_cnt_t;

endpackage

// ---- hw/rwc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module rwc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // asynchronous level in, settled level out
  input wire logic async_in,
  output logic sync_out
);

  logic ff1;
  logic ff2;
  logic ff3;

  // output moves only once the second and third stages agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ff1 <= RST_VAL;
      ff2 <= RST_VAL;
      ff3 <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      ff1 <= async_in;
      ff2 <= ff1;
      ff3 <= ff2;
      if (ff2 == ff3)
        sync_out <= ff3;
    end
  end

endmodule

`default_nettype wire

// ---- hw/rwc_filter.sv ----
`timescale 1ns/10ps
`default_nettype none

module rwc_filter #(
  parameter int MIN_CYC = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level in, persisted level out
  input wire logic level_in,
  output logic level_out
);

  logic [15:0] cnt;

  // a level shorter than the minimum is a glitch and never shows;
  // release is passed on at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= 16'h0000;
      level_out <= 1'b0;
    end
    else if (!level_in)
    begin
      cnt <= 16'h0000;
      level_out <= 1'b0;
    end
    else if (cnt == 16'(MIN_CYC - 1))
      level_out <= 1'b1;
    else
      cnt <= cnt + 16'h0001;
  end

endmodule

`default_nettype wire

// ---- hw/rwc_top.sv ----
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`include "rwc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module rwc_top #(
  parameter int STRETCH_CYC = `RWC_STRETCH_CYC,
  parameter int WDT_DIV_CYC = `RWC_WDT_DIV_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // reset sources, asynchronous
  input wire logic por_supply_ok,
  input wire logic ext_reset_pin_n,
  input wire logic brownout_below,
  // fuses, static
  input wire logic watchdog_safety_fuse,
  input wire logic [2:0] brownout_level_fuse,
  input wire logic reset_pin_enable,
  // core side
  input wire logic wdr_exec,
  input wire logic wdt_irq_ack,
  input wire logic adc_enable,
  // outputs
  output logic port_reset_n,
  output logic cpu_reset,
  output logic [15:0] fetch_addr,
  output logic watchdog_irq,
  output logic vref_enable
);

  function automatic rwc_pkg::rwc_wdt_cnt_t wdt_last(input logic [3:0] sel);
    logic [3:0] s;
    logic [20:0] p;
    s = (sel > `RWC_WDT_SEL_MAX) ? `RWC_WDT_SEL_MAX : sel;
    p = (`RWC_WDT_BASE_CYC << s) - 21'h000001;
    return p[19:0];
  endfunction

  rwc_pkg::rwc_state_e state;
  logic [15:0] stretch_cnt;
  logic por_phase;
  logic por_ok_s;
  logic ext_n_s;
  logic bod_s;
  logic ext_filt;
  logic bod_filt;
  logic fuse_level1;
  logic [2:0] fuse_bod;
  logic fuse_pin_en;
  logic bod_on;
  logic por_src;
  logic ext_src;
  logic bod_src;
  logic wd_src;
  logic any_src;
  logic ph_wr;
  logic ph_rd;
  logic ph_ok;
  logic [7:0] ph_idx;
  logic rd_done;
  logic [7:0] wdata;
  logic wr_ctrl;
  logic wr_cause;
  logic wr_cmp;
  logic wr_unlock;
  logic [2:0] unlock_win;
  logic win_open;
  logic irq_flag;
  logic irq_en;
  logic reset_en;
  logic [3:0] sel;
  logic reset_en_eff;
  logic [3:0] cause;
  logic cmp_bg;
  logic [9:0] div_cnt;
  logic osc_tick;
  rwc_pkg::rwc_wdt_cnt_t wdt_cnt;
  logic wdt_on;
  logic wdt_timeout;
  logic wdt_do_reset;
  logic [2:0] pulse_cnt;
  logic [7:0] rd_mux;

  rwc_sync #(.RST_VAL(1'b0)) u_sync_por (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(por_supply_ok),
    .sync_out(por_ok_s)
  );

  rwc_sync #(.RST_VAL(1'b1)) u_sync_ext (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(ext_reset_pin_n),
    .sync_out(ext_n_s)
  );

  rwc_sync #(.RST_VAL(1'b0)) u_sync_bod (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(brownout_below),
    .sync_out(bod_s)
  );

  rwc_filter #(.MIN_CYC(`RWC_EXT_MIN_CYC)) u_filt_ext (
    .hclk(hclk),
    .hresetn(hresetn),
    .level_in(~ext_n_s),
    .level_out(ext_filt)
  );

  rwc_filter #(.MIN_CYC(`RWC_BOD_MIN_CYC)) u_filt_bod (
    .hclk(hclk),
    .hresetn(hresetn),
    .level_in(bod_s),
    .level_out(bod_filt)
  );

  // fuses are straps: caught while the core is held in reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fuse_level1 <= 1'b1;
      fuse_bod <= `RWC_BOD_FUSE_OFF;
      fuse_pin_en <= 1'b1;
    end
    else if (cpu_reset)
    begin
      fuse_level1 <= watchdog_safety_fuse;
      fuse_bod <= brownout_level_fuse;
      fuse_pin_en <= reset_pin_enable;
    end
  end

  assign bod_on = (fuse_bod != `RWC_BOD_FUSE_OFF);
  assign por_src = ~por_ok_s;
  assign ext_src = ext_filt & fuse_pin_en & ~por_phase;
  assign bod_src = bod_filt & bod_on;
  assign wd_src = (pulse_cnt != 3'h0);
  assign any_src = por_src | ext_src | bod_src | wd_src;

  // raw pin levels reach the ports with no clock in the path
  assign port_reset_n = por_supply_ok
                      & ~(reset_pin_enable & ~ext_reset_pin_n)
                      & ~(bod_on & brownout_below)
                      & ~wd_src
                      & ~cpu_reset;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= rwc_pkg::rwc_hold;
      stretch_cnt <= 16'h0000;
      por_phase <= 1'b1;
      cpu_reset <= 1'b1;
    end
    else
    begin
      if (por_src)
        por_phase <= 1'b1;
      case (state)
        rwc_pkg::rwc_hold:
        begin
          cpu_reset <= 1'b1;
          stretch_cnt <= 16'h0000;
          if (!any_src)
            state <= rwc_pkg::rwc_stretch;
        end
        rwc_pkg::rwc_stretch:
        begin
          if (any_src)
            state <= rwc_pkg::rwc_hold;
          else if (stretch_cnt == 16'(STRETCH_CYC - 1))
          begin
            por_phase <= 1'b0;
            if (por_phase && ext_filt && fuse_pin_en)
              state <= rwc_pkg::rwc_hold;
            else
            begin
              state <= rwc_pkg::rwc_run;
              cpu_reset <= 1'b0;
            end
          end
          else
            stretch_cnt <= stretch_cnt + 16'h0001;
        end
        rwc_pkg::rwc_run:
        begin
          if (any_src)
          begin
            state <= rwc_pkg::rwc_hold;
            cpu_reset <= 1'b1;
          end
        end
        default:
        begin
          state <= rwc_pkg::rwc_hold;
          cpu_reset <= 1'b1;
        end
      endcase
    end
  end

  // fetch restarts from the vector every time reset is let go
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fetch_addr <= `RWC_RESET_VECTOR;
    else if (cpu_reset)
      fetch_addr <= `RWC_RESET_VECTOR;
  end

  // ahb-lite: writes have no wait state, reads take one so that a read
  // right after a write sees the written value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_ok <= 1'b0;
      ph_idx <= 8'h00;
      rd_done <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else if (hreadyout)
    begin
      ph_wr <= hsel & hready & htrans[1] & hwrite;
      ph_rd <= hsel & hready & htrans[1] & ~hwrite;
      ph_ok <= (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
      ph_idx <= haddr[9:2];
      rd_done <= 1'b0;
    end
    else
    begin
      rd_done <= 1'b1;
      hrdata <= {24'h000000, rd_mux};
    end
  end

  assign hreadyout = ~(ph_rd & ~rd_done);
  assign hresp = 1'b0;

  always_comb
  begin
    rd_mux = 8'h00;
    if (ph_ok)
    begin
      case (ph_idx)
        `RWC_IDX_WDT_CTRL:
          rd_mux = {irq_flag, irq_en, sel[3], 1'b0, reset_en_eff, sel[2:0]};
        `RWC_IDX_CAUSE:
          rd_mux = {4'h0, cause};
        `RWC_IDX_CMP_CTRL:
          rd_mux = {7'h00, cmp_bg};
        default:
          rd_mux = 8'h00;
      endcase
    end
  end

  assign wdata = hwdata[7:0];
  assign wr_ctrl = ph_wr & ph_ok & (ph_idx == `RWC_IDX_WDT_CTRL);
  assign wr_cause = ph_wr & ph_ok & (ph_idx == `RWC_IDX_CAUSE);
  assign wr_cmp = ph_wr & ph_ok & (ph_idx == `RWC_IDX_CMP_CTRL);
  assign wr_unlock = ph_wr & ph_ok & (ph_idx == `RWC_IDX_UNLOCK);
  assign win_open = (unlock_win != 3'h0);

  // the window is spent by the control write it guards
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      unlock_win <= 3'h0;
    else if (cpu_reset)
      unlock_win <= 3'h0;
    else if (wr_unlock)
      unlock_win <= (wdata == `RWC_UNLOCK_SIG) ? `RWC_UNLOCK_WIN : 3'h0;
    else if (wr_ctrl)
      unlock_win <= 3'h0;
    else if (win_open)
      unlock_win <= unlock_win - 3'h1;
  end

  assign reset_en_eff = reset_en | cause[`RWC_CAUSE_WDT] | ~fuse_level1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reset_en <= 1'b0;
      sel <= 4'h0;
    end
    else if (cpu_reset)
    begin
      reset_en <= 1'b0;
      sel <= 4'h0;
    end
    else if (wr_ctrl)
    begin
      if (!fuse_level1)
      begin
        if (win_open)
          sel <= {wdata[`RWC_WDC_SEL3], wdata[`RWC_WDC_SEL_HI:0]};
      end
      else if (wdata[`RWC_WDC_RESET_EN] || !reset_en_eff || win_open)
      begin
        reset_en <= wdata[`RWC_WDC_RESET_EN];
        sel <= {wdata[`RWC_WDC_SEL3], wdata[`RWC_WDC_SEL_HI:0]};
      end
    end
  end

  // an unprotected attempt to disable leaves reset_en and sel as they were; irq_en still takes the written bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_en <= 1'b0;
    else if (cpu_reset)
      irq_en <= 1'b0;
    else if (wdt_irq_ack && reset_en_eff)
      irq_en <= 1'b0;
    else if (wr_ctrl)
      irq_en <= wdata[`RWC_WDC_IRQ_EN];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_flag <= 1'b0;
    else if (cpu_reset)
      irq_flag <= 1'b0;
    else if (wdt_timeout && !wdt_do_reset && irq_en)
      irq_flag <= 1'b1;
    else if (wdt_irq_ack || (wr_ctrl && wdata[`RWC_WDC_IRQ_FLAG]))
      irq_flag <= 1'b0;
  end

  assign watchdog_irq = irq_flag & irq_en;

  // the oscillator rate is an enable pulse off the bus clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt <= 10'h000;
      osc_tick <= 1'b0;
    end
    else if (div_cnt == 10'(WDT_DIV_CYC - 1))
    begin
      div_cnt <= 10'h000;
      osc_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 10'h001;
      osc_tick <= 1'b0;
    end
  end

  assign wdt_on = reset_en_eff | irq_en;
  assign wdt_timeout = osc_tick & wdt_on & (wdt_cnt == wdt_last(sel));
  assign wdt_do_reset = ~fuse_level1 | (reset_en_eff & (~irq_en | irq_flag));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdt_cnt <= 20'h00000;
    else if (wdr_exec || !wdt_on || cpu_reset)
      wdt_cnt <= 20'h00000;
    else if (wdt_timeout)
      wdt_cnt <= 20'h00000;
    else if (osc_tick)
      wdt_cnt <= wdt_cnt + 20'h00001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pulse_cnt <= 3'h0;
    else if (wdt_timeout && wdt_do_reset)
      pulse_cnt <= 3'(`RWC_WDT_PULSE_CYC);
    else if (wd_src)
      pulse_cnt <= pulse_cnt - 3'h1;
  end

  // cause flags survive every reset but power-on, which leaves only the POR flag; a new cause beats a software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cause <= 4'h0;
    else if (por_src)
      cause <= 4'h1 << `RWC_CAUSE_POR;
    else
    begin
      if (wd_src)
        cause[`RWC_CAUSE_WDT] <= 1'b1;
      else if (wr_cause && !wdata[`RWC_CAUSE_WDT])
        cause[`RWC_CAUSE_WDT] <= 1'b0;
      if (bod_src)
        cause[`RWC_CAUSE_BOD] <= 1'b1;
      else if (wr_cause && !wdata[`RWC_CAUSE_BOD])
        cause[`RWC_CAUSE_BOD] <= 1'b0;
      if (ext_src)
        cause[`RWC_CAUSE_EXT] <= 1'b1;
      else if (wr_cause && !wdata[`RWC_CAUSE_EXT])
        cause[`RWC_CAUSE_EXT] <= 1'b0;
      if (wr_cause && !wdata[`RWC_CAUSE_POR])
        cause[`RWC_CAUSE_POR] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_bg <= 1'b0;
      vref_enable <= 1'b0;
    end
    else
    begin
      if (cpu_reset)
        cmp_bg <= 1'b0;
      else if (wr_cmp)
        cmp_bg <= wdata[`RWC_CMP_BANDGAP];
      vref_enable <= bod_on | cmp_bg | adc_enable;
    end
  end

endmodule

`default_nettype wire

// ---- tb/rwc_top_checker.sv ----
`timescale 1ns/10ps
`default_nettype none

module rwc_top_checker #(
  parameter int STRETCH_CYC = 20
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // sources and core side
  input wire logic por_supply_ok,
  input wire logic brownout_below,
  input wire logic [2:0] brownout_level_fuse,
  input wire logic adc_enable,
  input wire logic wdt_irq_ack,
  // outputs
  input wire logic port_reset_n,
  input wire logic cpu_reset,
  input wire logic [15:0] fetch_addr,
  input wire logic watchdog_irq,
  input wire logic vref_enable
);
  int unsigned hold_cnt;
  int unsigned low_cnt;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // length of the current internal reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_cnt <= 0;
    else
      hold_cnt <= cpu_reset ? hold_cnt + 1 : 0;
  end

  // length of the current supply dip
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_cnt <= 0;
    else
      low_cnt <= brownout_below ? low_cnt + 1 : 0;
  end

  sequence rd_take;
    hsel && hready && htrans[1] && !hwrite && hreadyout;
  endsequence

  sequence rd_done;
    !hreadyout ##1 (hreadyout && hrdata[31:8] == 24'h0);
  endsequence

  read_wait_a: assert property (rd_take |=> rd_done)
    else $error("read data phase not one wait state");
  write_nowait_a: assert property ((hsel && hready && htrans[1] && hwrite && hreadyout) |=> hreadyout)
    else $error("write data phase stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  fetch_vector_a: assert property (cpu_reset |-> fetch_addr == 16'h0000)
    else $error("fetch address not reset vector");
  port_reset_a: assert property ((cpu_reset || !por_supply_ok) |-> !port_reset_n)
    else $error("port pins not held in reset");
  stretch_len_a: assert property ($fell(cpu_reset) |-> hold_cnt >= STRETCH_CYC)
    else $error("internal reset released early");
  supply_drop_a: assert property ($fell(por_supply_ok) |-> ##[1:6] cpu_reset)
    else $error("supply drop did not reset");
  brownout_rst_a: assert property ((low_cnt == 230 && brownout_level_fuse != 3'h7) |-> cpu_reset)
    else $error("long brown-out did not reset");
  // fuse straps are only taken while in reset, so judge the reference once running
  vref_on_a: assert property ((!cpu_reset && (brownout_level_fuse != 3'h7 || adc_enable)) |=> vref_enable)
    else $error("reference off while requested");
  irq_ack_a: assert property (wdt_irq_ack |=> !watchdog_irq)
    else $error("interrupt stays after service");
endmodule

bind rwc_top rwc_top_checker #(.STRETCH_CYC(STRETCH_CYC)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .por_supply_ok(por_supply_ok), .brownout_below(brownout_below),
  .brownout_level_fuse(brownout_level_fuse), .adc_enable(adc_enable),
  .wdt_irq_ack(wdt_irq_ack), .port_reset_n(port_reset_n), .cpu_reset(cpu_reset),
  .fetch_addr(fetch_addr), .watchdog_irq(watchdog_irq), .vref_enable(vref_enable)
);

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rwc_cfg.svh"

`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module tb_top;
  localparam int STR = 20;
  localparam logic [7:0] WC = `RWC_IDX_WDT_CTRL;
  localparam logic [7:0] CA = `RWC_IDX_CAUSE;
  localparam logic [7:0] CM = `RWC_IDX_CMP_CTRL;
  logic hclk, hresetn, hsel, hwrite, por, ext, brownout_detector, wfuse, pin_en, wdr, ack, adc;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, bfuse;
  logic hreadyout, hresp, port_reset_n, cpu_reset, watchdog_irq, vref_enable;
  logic [15:0] fetch_addr;
  int n_mismatch = 0;
  int num_checks = 0;
  int wait_n;

  rwc_top #(.STRETCH_CYC(STR), .WDT_DIV_CYC(2)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .por_supply_ok(por), .ext_reset_pin_n(ext),
    .brownout_below(brownout_detector), .watchdog_safety_fuse(wfuse), .brownout_level_fuse(bfuse),
    .reset_pin_enable(pin_en), .wdr_exec(wdr), .wdt_irq_ack(ack), .adc_enable(adc),
    .port_reset_n(port_reset_n), .cpu_reset(cpu_reset), .fetch_addr(fetch_addr),
    .watchdog_irq(watchdog_irq), .vref_enable(vref_enable)
  );

  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // ready and data are looked at mid-cycle, where they have settled;
  // no wait limit here, a stuck slave is left to the watchdog process
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end
    while (r !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    wait_rdy(d);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy(rd);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask

  task automatic unlock();
    bus(1'b1, `RWC_IDX_UNLOCK, `RWC_UNLOCK_SIG);
  endtask

  task automatic wait_for(input logic irq, input logic v, input int lim);
    wait_n = 0;
    do
    begin
      @(negedge hclk);
      wait_n++;
    end
    while (((irq ? watchdog_irq : cpu_reset) !== v) && wait_n < lim);
    @(posedge hclk);
  endtask

  task automatic rel();
    wait_for(1'b0, 1'b0, 2000);
    `CHK(cpu_reset, 1'b0)
    `CHK(wait_n >= STR, 1'b1)
  endtask

  task automatic irq_ack();
    ack <= 1'b1;
    tick(1);
    ack <= 1'b0;
    tick(1);
  endtask

  initial
  begin
    {hsel, htrans, hwrite, hwdata, haddr, brownout_detector, wdr, ack, adc, hresetn, por} = '0;
    {ext, wfuse, pin_en} = 3'b111;
    hsize = 3'h2;
    bfuse = 3'h7;
    tick(10);
    hresetn <= 1'b1;
    tick(3);
    `CHK(port_reset_n, 1'b0)
    `CHK(fetch_addr, 16'h0000)
    por <= 1'b1;
    rel();
    rchk(CA, 8'h01);
    rchk(WC, 8'h00);
    bus(1'b1, CA, 8'hff);
    rchk(CA, 8'h01);
    bus(1'b1, CA, 8'h00);
    rchk(CA, 8'h00);
    rchk(8'h30, 8'h00);
    bus(1'b1, WC, 8'h21);
    rchk(WC, 8'h21);
    bus(1'b1, WC, 8'h08);
    bus(1'b1, WC, 8'h00);
    rchk(WC, 8'h08);
    unlock();
    tick(6);
    bus(1'b1, WC, 8'h00);
    rchk(WC, 8'h08);
    unlock();
    bus(1'b1, WC, 8'h00);
    rchk(WC, 8'h00);
    adc <= 1'b1;
    tick(3);
    `CHK(vref_enable, 1'b1)
    adc <= 1'b0;
    bus(1'b1, CM, 8'h01);
    tick(2);
    `CHK(vref_enable, 1'b1)
    bus(1'b1, CM, 8'h00);
    tick(2);
    `CHK(vref_enable, 1'b0)
    bus(1'b1, WC, 8'h40);
    wait_for(1'b1, 1'b1, 5000);
    `CHK(wait_n inside {[4000:4200]}, 1'b1)
    `CHK(cpu_reset, 1'b0)
    irq_ack();
    `CHK(watchdog_irq, 1'b0)
    rchk(WC, 8'h40);
    bus(1'b1, WC, 8'h48);
    wait_for(1'b1, 1'b1, 5000);
    irq_ack();
    rchk(WC, 8'h08);
    repeat (6)
    begin
      tick(1000);
      wdr <= 1'b1;
      tick(1);
      wdr <= 1'b0;
    end
    `CHK(cpu_reset, 1'b0)
    wait_for(1'b0, 1'b1, 5000);
    `CHK(cpu_reset, 1'b1)
    rel();
    rchk(CA, 8'h08);
    unlock();
    bus(1'b1, WC, 8'h00);
    rchk(WC, 8'h08);
    bus(1'b1, CA, 8'h00);
    bus(1'b1, WC, 8'h00);
    rchk(WC, 8'h00);
    ext <= 1'b0;
    tick(300);
    `CHK(cpu_reset, 1'b1)
    `CHK(port_reset_n, 1'b0)
    // fuses are straps: change one only while the core is held in reset
    bfuse <= 3'h4;
    tick(2);
    ext <= 1'b1;
    rel();
    rchk(CA, 8'h02);
    brownout_detector <= 1'b1;
    tick(100);
    brownout_detector <= 1'b0;
    tick(10);
    `CHK(cpu_reset, 1'b0)
    `CHK(vref_enable, 1'b1)
    brownout_detector <= 1'b1;
    tick(300);
    `CHK(cpu_reset, 1'b1)
    brownout_detector <= 1'b0;
    rel();
    rchk(CA, 8'h06);
    por <= 1'b0;
    #1;
    `CHK(port_reset_n, 1'b0)
    tick(10);
    `CHK(cpu_reset, 1'b1)
    por <= 1'b1;
    rel();
    rchk(CA, 8'h01);
    hresetn <= 1'b0;
    wfuse <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    rel();
    rchk(WC, 8'h08);
    bus(1'b1, WC, 8'h01);
    rchk(WC, 8'h08);
    unlock();
    bus(1'b1, WC, 8'h01);
    rchk(WC, 8'h09);
    close_out();
  end

  initial
  begin
    tick(60000);
    n_mismatch++;
    close_out();
  end
endmodule

`default_nettype wire
